// ### msrp_consts.svh
// constants of the meter serial readout port: timing counts, record layout, commands
// assumes a 100 MHz system clock on both ends
`ifndef MSRP_CONSTS_SVH
`define MSRP_CONSTS_SVH
`define MSRP_SYS_PERIOD_NS 10
`define MSRP_STEP_NS 30
`define MSRP_STEP_CYC (`MSRP_STEP_NS / `MSRP_SYS_PERIOD_NS + 1)
`define MSRP_LATCH_NS 500
`define MSRP_LATCH_CYC (`MSRP_LATCH_NS / `MSRP_SYS_PERIOD_NS + 1)
`define MSRP_HALF_CYC 8
`define MSRP_REC_BITS 32
`define MSRP_MAX_RECS 8
`define MSRP_TOTAL_BITS 9'h100
`define MSRP_SWAP_XOR 3'h4
`define MSRP_SWAP_CMD 8'hff
`define MSRP_PARITY_LSB 28
`define MSRP_BYTE_LAST 3'h7
`define MSRP_WORD_LAST 5'h1f
`endif

// ### msrp_pkg.sv
// types and shared functions of the meter serial readout port
// assumes msrp_consts.svh is on the include path
`default_nettype none
package msrp_pkg;
    `include "msrp_consts.svh"

    typedef logic [`MSRP_MAX_RECS-1:0][`MSRP_REC_BITS-1:0] msrp_recs_t;

    typedef enum logic [1:0] {MSRP_OP_LATCH, MSRP_OP_READ, MSRP_OP_SWAP_READ, MSRP_OP_RESET} msrp_op_t;

    typedef enum logic [2:0] {MSRP_H_IDLE, MSRP_H_HOLD, MSRP_H_SEL, MSRP_H_CLR, MSRP_H_WR, MSRP_H_RD,
                              MSRP_H_END, MSRP_H_GAP} msrp_hstate_t;

    typedef struct packed {
        msrp_recs_t latch;
        logic swap;
        logic orderLsb;
        logic oe;
        logic [2:0] wrCnt;
        logic [7:0] wrByte;
        logic prevClk;
        logic rstPulse;
    } msrp_dev_sys_t;

    typedef struct packed {
        logic [8:0] bitCnt;
        logic dataOut;
    } msrp_dev_link_t;

    typedef struct packed {
        msrp_hstate_t state;
        msrp_op_t op;
        logic [15:0] timer;
        logic [8:0] bitCnt;
        logic [8:0] lastBit;
        logic [31:0] word;
        logic [31:0] wordOut;
        logic wordValid;
        logic ready;
        logic selN;
        logic strobe;
        logic sclk;
        logic dOut;
        logic dOe;
    } msrp_host_t;

    // position of a serial bit inside its record word
    function automatic logic [4:0] msrp_bit_pos(input logic [4:0] cnt, input logic lsbFirst);
        msrp_bit_pos = {cnt[4:3], lsbFirst ? cnt[2:0] : ~cnt[2:0]};
    endfunction : msrp_bit_pos
endpackage : msrp_pkg
`default_nettype wire

// ### msrp_if.sv
// the four-pin link between master and metering device
// assumes every pin has a weak pull-up; an undriven data line reads high
`default_nettype none
interface msrp_if;
    logic portSelectN;
    logic latchDirectionStrobe;
    logic serialBitClock;
    logic dataHost;
    logic dataHostOe;
    logic dataDev;
    logic dataDevOe;
    logic serialDataIo;

    // pull-up resolution of the shared data line
    assign serialDataIo = dataDevOe ? dataDev : (dataHostOe ? dataHost : 1'b1);

    modport dev (
        input portSelectN,
        input latchDirectionStrobe,
        input serialBitClock,
        input serialDataIo,
        output dataDev,
        output dataDevOe
    );

    modport host (
        output portSelectN,
        output latchDirectionStrobe,
        output serialBitClock,
        output dataHost,
        output dataHostOe,
        input serialDataIo
    );
endinterface : msrp_if
`default_nettype wire

// ### msrp_sync.sv
// two flip-flop synchroniser for pin levels
// assumes idle pins are high, so it resets to all ones
`default_nettype none
module msrp_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] out;
    } msrp_sync_t;

    msrp_sync_t s;
    msrp_sync_t next_s;

    always_comb begin
        next_s.meta = din;
        next_s.out = s.meta;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s <= '1;
        end else begin
            s <= next_s;
        end
    end

    assign dout = s.out;
endmodule : msrp_sync
`default_nettype wire

// ### msrp_device.sv
// metering device end of the serial readout port: latches, record shifter, command and reset detection
// assumes a 100 MHz measurement clock and a bit clock made by the master that stops between frames
// assumes recordIn and bitOrderSelect come from logic on clk_sys
// the shifter runs on the bit clock's falling edge, held in reset outside read frames
`default_nettype none
`include "msrp_consts.svh"

module msrp_device (
    input wire logic clk_sys,
    input wire logic nrst,
    msrp_if.dev link,
    input wire msrp_pkg::msrp_recs_t recordIn,
    input wire logic bitOrderSelect,
    output logic remoteResetPulse,
    output logic swapActive
);
    import msrp_pkg::*;

    // ****************************************************
    // parity coding of a record
    // ****************************************************

    function automatic logic [31:0] parityCode(input logic [31:0] w);
        logic [3:0] p;
        p = 4'h0;
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 7; j++) begin
                p[i] = p[i] ^ w[4 * j + i];
            end
        end
        parityCode = {p, w[`MSRP_PARITY_LSB-1:0]};
    endfunction : parityCode

    // ****************************************************
    // pin synchronisers for the system side
    // ****************************************************

    logic [3:0] pinSync;
    logic selS;
    logic strS;
    logic clkS;
    logic datS;

    msrp_sync #(
        .W(4)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .din({link.portSelectN, link.latchDirectionStrobe, link.serialBitClock, link.serialDataIo}),
        .dout(pinSync)
    );

    // a high or undriven pin counts as inactive
    assign selS = pinSync[3];
    assign strS = pinSync[2];
    assign clkS = pinSync[1];
    assign datS = pinSync[0];

    // ****************************************************
    // system domain state
    // ****************************************************

    msrp_dev_sys_t s;
    msrp_dev_sys_t next_s;
    logic [7:0] rxByte;
    logic clkFall;

    assign rxByte = {s.wrByte[6:0], datS};
    assign clkFall = s.prevClk & ~clkS;

    always_comb begin
        next_s = s;
        next_s.rstPulse = 1'b0;
        next_s.prevClk = clkS;
        // data pin driven only while selected in read direction
        next_s.oe = ~selS & strS;
        // select, strobe and clock high: idle, write bit count cleared
        if (selS & strS & clkS) begin
            next_s.wrCnt = 3'h0;
        end
        // latching pulse while select idle samples all records
        if (selS & ~strS) begin
            for (int i = 0; i < `MSRP_MAX_RECS; i++) begin
                next_s.latch[i] = parityCode(recordIn[i]);
            end
        end
        // write direction: bits taken at each clock activation
        if (~selS & ~strS) begin
            if (clkFall) begin
                next_s.wrByte = rxByte;
                next_s.wrCnt = s.wrCnt + 3'h1;
                if (s.wrCnt == `MSRP_BYTE_LAST && rxByte == `MSRP_SWAP_CMD) begin
                    next_s.swap = 1'b1;
                end
            end
        end else begin
            next_s.wrCnt = 3'h0;
        end
        // swap lasts only until select returns idle
        if (selS) begin
            next_s.swap = 1'b0;
        end
        // bit order taken only while deselected, so the shifter sees it constant
        if (selS) begin
            next_s.orderLsb = bitOrderSelect;
        end
        // bit clock activation while select and strobe idle
        if (selS & strS & clkFall) begin
            next_s.rstPulse = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s <= '{
                latch: '0,
                swap: 1'b0,
                orderLsb: 1'b0,
                oe: 1'b0,
                wrCnt: 3'h0,
                wrByte: 8'h00,
                prevClk: 1'b1,
                rstPulse: 1'b0
            };
        end else begin
            s <= next_s;
        end
    end

    // ****************************************************
    // link domain shifter
    // ****************************************************

    msrp_dev_link_t l;
    msrp_dev_link_t next_l;
    logic linkRun;
    logic [2:0] recSel;
    logic [4:0] bitSel;
    logic [31:0] recWord;

    // shifter runs only while selected for reading; strobe low or deselect clears it
    assign linkRun = nrst & ~link.portSelectN & link.latchDirectionStrobe;

    // record order, optionally swapped by halves
    assign recSel = l.bitCnt[7:5] ^ (s.swap ? `MSRP_SWAP_XOR : 3'h0);
    assign recWord = s.latch[recSel];
    // latches, swap and order bit only change while the shifter is held in reset
    // byte index rises from least significant, bit order per byte selectable
    assign bitSel = msrp_bit_pos(l.bitCnt[4:0], s.orderLsb);

    always_comb begin
        next_l = l;
        if (l.bitCnt < `MSRP_TOTAL_BITS) begin
            // each activation puts out the next bit, held through the following trailing edge
            next_l.dataOut = recWord[bitSel];
            next_l.bitCnt = l.bitCnt + 9'h1;
        end else begin
            next_l.dataOut = 1'b1;
        end
    end

    always_ff @(negedge link.serialBitClock or negedge linkRun) begin
        if (!linkRun) begin
            l <= '{
                bitCnt: 9'h000,
                dataOut: 1'b1
            };
        end else begin
            l <= next_l;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************

    assign link.dataDev = l.dataOut;
    assign link.dataDevOe = s.oe;
    assign remoteResetPulse = s.rstPulse;
    assign swapActive = s.swap;
endmodule : msrp_device
`default_nettype wire

// ### msrp_host.sv
// master end of the serial readout port: latch, read, swapped read and remote reset sequences
// assumes commands from logic on clk_sys; the bit clock is divided down from clk_sys
`default_nettype none
`include "msrp_consts.svh"

module msrp_host #(
    parameter int HALF_CYC = `MSRP_HALF_CYC
) (
    input wire logic clk_sys,
    input wire logic nrst,
    msrp_if.host link,
    input wire logic cmdValid,
    input wire msrp_pkg::msrp_op_t cmdOp,
    input wire logic [3:0] cmdRecords,
    input wire logic bitOrderSelect,
    output logic cmdReady,
    output logic [31:0] wordData,
    output logic wordValid
);
    import msrp_pkg::*;

    // ****************************************************
    // data line synchroniser
    // ****************************************************

    logic datS;

    msrp_sync #(
        .W(1)
    ) u_data_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .din(link.serialDataIo),
        .dout(datS)
    );

    // ****************************************************
    // sequencer
    // ****************************************************

    msrp_host_t h;
    msrp_host_t next_h;
    logic done;
    logic [3:0] recs;
    logic [4:0] pos;

    assign done = (h.timer == 16'h0000);
    assign recs = (cmdRecords == 4'h0 || cmdRecords > 4'h8) ? 4'h8 : cmdRecords;
    assign pos = msrp_bit_pos(h.bitCnt[4:0], bitOrderSelect);

    always_comb begin
        next_h = h;
        next_h.wordValid = 1'b0;
        if (!done) begin
            next_h.timer = h.timer - 16'h0001;
        end
        unique case (h.state)
            MSRP_H_IDLE: begin
                if (cmdValid) begin
                    next_h.ready = 1'b0;
                    next_h.op = cmdOp;
                    next_h.lastBit = {1'b0, 3'(recs - 4'h1), `MSRP_WORD_LAST};
                    next_h.state = MSRP_H_HOLD;
                    unique case (cmdOp)
                        MSRP_OP_LATCH: begin
                            next_h.strobe = 1'b0;
                            next_h.timer = 16'(`MSRP_LATCH_CYC);
                        end
                        MSRP_OP_RESET: begin
                            next_h.sclk = 1'b0;
                            next_h.timer = 16'(`MSRP_STEP_CYC);
                        end
                        default: begin
                            next_h.selN = 1'b0;
                            next_h.timer = 16'(`MSRP_STEP_CYC);
                            next_h.state = MSRP_H_SEL;
                        end
                    endcase
                end
            end
            MSRP_H_HOLD: begin
                if (done) begin
                    next_h.strobe = 1'b1;
                    next_h.sclk = 1'b1;
                    next_h.timer = 16'(`MSRP_STEP_CYC);
                    next_h.state = MSRP_H_GAP;
                end
            end
            MSRP_H_SEL: begin
                if (done) begin
                    next_h.strobe = 1'b0;
                    next_h.timer = 16'(`MSRP_STEP_CYC);
                    next_h.bitCnt = 9'h000;
                    if (h.op == MSRP_OP_SWAP_READ) begin
                        next_h.dOe = 1'b1;
                        next_h.dOut = 1'b1;
                        next_h.state = MSRP_H_WR;
                    end else begin
                        next_h.state = MSRP_H_CLR;
                    end
                end
            end
            MSRP_H_CLR: begin
                if (done) begin
                    next_h.strobe = 1'b1;
                    next_h.timer = 16'(`MSRP_STEP_CYC);
                    next_h.bitCnt = 9'h000;
                    next_h.state = MSRP_H_RD;
                end
            end
            MSRP_H_WR: begin
                if (done) begin
                    next_h.timer = 16'(HALF_CYC);
                    if (h.sclk) begin
                        next_h.sclk = 1'b0;
                    end else begin
                        next_h.sclk = 1'b1;
                        next_h.bitCnt = h.bitCnt + 9'h1;
                        if (h.bitCnt[2:0] == `MSRP_BYTE_LAST) begin
                            next_h.dOe = 1'b0;
                            next_h.timer = 16'(`MSRP_STEP_CYC);
                            next_h.state = MSRP_H_CLR;
                        end
                    end
                end
            end
            MSRP_H_RD: begin
                if (done) begin
                    next_h.timer = 16'(HALF_CYC);
                    if (h.sclk) begin
                        next_h.sclk = 1'b0;
                    end else begin
                        // sample on the trailing edge, mid-bit
                        next_h.sclk = 1'b1;
                        next_h.word[pos] = datS;
                        next_h.bitCnt = h.bitCnt + 9'h1;
                        if (h.bitCnt[4:0] == `MSRP_WORD_LAST) begin
                            next_h.wordValid = 1'b1;
                            next_h.wordOut = next_h.word;
                        end
                        if (h.bitCnt == h.lastBit) begin
                            next_h.timer = 16'(`MSRP_STEP_CYC);
                            next_h.state = MSRP_H_END;
                        end
                    end
                end
            end
            MSRP_H_END: begin
                if (done) begin
                    next_h.selN = 1'b1;
                    next_h.timer = 16'(`MSRP_STEP_CYC);
                    next_h.state = MSRP_H_GAP;
                end
            end
            MSRP_H_GAP: begin
                if (done) begin
                    next_h.ready = 1'b1;
                    next_h.state = MSRP_H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            h <= '{state: MSRP_H_IDLE, op: MSRP_OP_LATCH, timer: 16'h0000, bitCnt: 9'h000, lastBit: 9'h000,
                   word: 32'h0, wordOut: 32'h0, wordValid: 1'b0, ready: 1'b1, selN: 1'b1, strobe: 1'b1,
                   sclk: 1'b1, dOut: 1'b1, dOe: 1'b0};
        end else begin
            h <= next_h;
        end
    end

    assign link.portSelectN = h.selN;
    assign link.latchDirectionStrobe = h.strobe;
    assign link.serialBitClock = h.sclk;
    assign link.dataHost = h.dOut;
    assign link.dataHostOe = h.dOe;
    assign cmdReady = h.ready;
    assign wordData = h.wordOut;
    assign wordValid = h.wordValid;
endmodule : msrp_host
`default_nettype wire

// ### msrp_monitor.sv
// checker of the link pins between master and metering device
// assumes plain inputs tied to the link interface and a 100 MHz clk_sys
`default_nettype none
module msrp_monitor (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic portSelectN,
    input wire logic latchDirectionStrobe,
    input wire logic serialBitClock,
    input wire logic dataHostOe,
    input wire logic dataDevOe,
    input wire logic serialDataIo
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] lowCnt;
    logic [8:0] frameBits;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ****************
    // helper counters
    // ****************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            lowCnt <= 8'h00;
            frameBits <= 9'h000;
        end else begin
            if (!portSelectN || latchDirectionStrobe)
                lowCnt <= 8'h00;
            else if (lowCnt != 8'hff)
                lowCnt <= lowCnt + 8'h01;
            if (portSelectN || !latchDirectionStrobe)
                frameBits <= 9'h000;
            else if ($fell(serialBitClock))
                frameBits <= frameBits + 9'h001;
        end
    end
    // ****************
    // pin rules
    // ****************
    a_sel_from_idle: assert property ($fell(portSelectN)
        |-> $past(latchDirectionStrobe) && $past(serialBitClock))
        else $error("select fell outside idle");
    a_idle_quiet: assert property (portSelectN [*6] |-> !dataDevOe && serialDataIo)
        else $error("device active while deselected");
    a_read_drive: assert property ((!portSelectN && latchDirectionStrobe) [*6] |-> dataDevOe)
        else $error("device not driving in read");
    a_write_listen: assert property ((!portSelectN && !latchDirectionStrobe) [*6] |-> !dataDevOe)
        else $error("device driving in write");
    a_data_on_fall: assert property ((!portSelectN && latchDirectionStrobe && dataDevOe
        && $stable(portSelectN) && $stable(latchDirectionStrobe) && $stable(dataDevOe) && $changed(serialDataIo))
        |-> $fell(serialBitClock))
        else $error("data changed off the clock activation");
    a_latch_long: assert property (($rose(latchDirectionStrobe) && portSelectN && $past(portSelectN))
        |-> lowCnt > 8'h32)
        else $error("latch pulse too short");
    a_reset_step: assert property (($fell(serialBitClock) && portSelectN) |-> (!serialBitClock) [*4])
        else $error("reset step too short");
    a_frame_bits: assert property (frameBits <= 9'h100)
        else $error("more than eight records clocked");
    a_abort_release: assert property ($rose(portSelectN) |-> ##[1:5] !dataDevOe)
        else $error("data driver kept after select release");
    c_reset: cover property ($fell(serialBitClock) && portSelectN);
    c_swap: cover property (dataHostOe && !portSelectN);
    c_full: cover property (frameBits == 9'h100);
endmodule : msrp_monitor
`default_nettype wire

// ### meter_serial_readout_port_tb.sv
// self-checking bench: master and metering device joined by the link interface
// assumes package, interface, both ends and the checker compiled before it
`default_nettype none
module meter_serial_readout_port_tb;
    import msrp_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HALF = 8;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    msrp_recs_t recordIn;
    msrp_recs_t latched;
    logic bitOrderSelect = 1'b0;
    logic cmdValid = 1'b0;
    msrp_op_t cmdOp = MSRP_OP_LATCH;
    logic [3:0] cmdRecords = 4'h0;
    logic cmdReady, wordValid, remoteResetPulse, swapActive, swapSeen;
    logic [31:0] wordData;
    logic [31:0] words[$];
    logic wireBits[$];
    int fail_count = 0;
    int checked = 0;
    int rstCount = 0;
    msrp_if link();
    msrp_device msrp_device_i (.clk_sys(clk_sys), .nrst(nrst), .link(link), .recordIn(recordIn),
        .bitOrderSelect(bitOrderSelect), .remoteResetPulse(remoteResetPulse), .swapActive(swapActive));
    msrp_host #(.HALF_CYC(HALF)) msrp_host_i (.clk_sys(clk_sys), .nrst(nrst), .link(link),
        .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdRecords(cmdRecords), .bitOrderSelect(bitOrderSelect),
        .cmdReady(cmdReady), .wordData(wordData), .wordValid(wordValid));
    msrp_monitor msrp_monitor_i (.clk_sys(clk_sys), .nrst(nrst), .portSelectN(link.portSelectN),
        .latchDirectionStrobe(link.latchDirectionStrobe), .serialBitClock(link.serialBitClock),
        .dataHostOe(link.dataHostOe), .dataDevOe(link.dataDevOe), .serialDataIo(link.serialDataIo));
    // ****************
    // observers
    // ****************
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (wordValid === 1'b1)
            words.push_back(wordData);
        if (remoteResetPulse === 1'b1)
            rstCount++;
        if (swapActive === 1'b1)
            swapSeen = 1'b1;
    end
    always @(posedge link.serialBitClock) begin
        if (link.portSelectN === 1'b0 && link.latchDirectionStrobe === 1'b1)
            wireBits.push_back(link.serialDataIo);
    end
    // ****************
    // helpers
    // ****************
    function automatic msrp_recs_t pattern(input logic [31:0] base);
        msrp_recs_t r;
        for (int i = 0; i < 8; i++)
            r[i] = base + 32'h1111_1111 * 32'(i);
        return r;
    endfunction : pattern
    function automatic logic [31:0] exp_rec(input logic [31:0] r);
        logic [3:0] p;
        p = 4'h0;
        for (int n = 0; n < 7; n++)
            p = p ^ r[4*n +: 4];
        return {p, r[27:0]};
    endfunction : exp_rec
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp_word
    task automatic run_cmd(input msrp_op_t op, input logic [3:0] n);
        int k;
        k = 0;
        words.delete();
        wireBits.delete();
        @(posedge clk_sys);
        cmdValid <= 1'b1;
        cmdOp <= op;
        cmdRecords <= n;
        @(posedge clk_sys);
        cmdValid <= 1'b0;
        do begin
            @(negedge clk_sys);
            k++;
        end while (cmdReady !== 1'b1 && k < 20000);
        cmp_word({31'h0, cmdReady}, 32'h1, "command end");
    endtask : run_cmd
    task automatic read_check(input msrp_op_t op, input logic [3:0] code, input int n, input int sh);
        logic [31:0] e;
        run_cmd(op, code);
        cmp_word(32'(words.size()), 32'(n), "word count");
        cmp_word(32'(wireBits.size()), 32'(32 * n), "wire bit count");
        for (int i = 0; i < n; i++) begin
            e = exp_rec(latched[(i + sh) % 8]);
            cmp_word(words[i], e, "record");
        end
        e = exp_rec(latched[sh]);
        for (int b = 0; b < 8; b++)
            cmp_word({31'h0, wireBits[b]}, {31'h0, e[bitOrderSelect ? b : 7 - b]}, "wire bit");
    endtask : read_check
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test
    // ****************
    // tests
    // ****************
    initial begin
        repeat (60000) @(posedge clk_sys);
        fail_count++;
        $display("ERROR %0t watchdog expired", $time);
        end_of_test();
    end
    initial begin
        recordIn = pattern(32'h0123_4567);
        latched = '0;
        swapSeen = 1'b0;
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        @(negedge clk_sys);
        cmp_word({28'h0, link.portSelectN, link.latchDirectionStrobe, link.serialBitClock, link.serialDataIo},
            32'hf, "idle pins");
        run_cmd(MSRP_OP_LATCH, 4'h0);
        latched = recordIn;
        read_check(MSRP_OP_READ, 4'h0, 8, 0);
        $display("test 1 full read done");
        @(posedge clk_sys);
        recordIn <= pattern(32'hfedc_ba98);
        bitOrderSelect <= 1'b1;
        read_check(MSRP_OP_READ, 4'h3, 3, 0);
        $display("test 2 repeat read lsb first done");
        @(posedge clk_sys);
        bitOrderSelect <= 1'b0;
        swapSeen = 1'b0;
        read_check(MSRP_OP_SWAP_READ, 4'h9, 8, 4);
        cmp_word({31'h0, swapSeen}, 32'h1, "swap seen");
        $display("test 3 swapped read done");
        swapSeen = 1'b0;
        read_check(MSRP_OP_READ, 4'h8, 8, 0);
        cmp_word({31'h0, swapSeen}, 32'h0, "swap kept");
        $display("test 4 order restored done");
        rstCount = 0;
        run_cmd(MSRP_OP_RESET, 4'h0);
        cmp_word(32'(rstCount), 32'h1, "reset pulses");
        run_cmd(MSRP_OP_LATCH, 4'h0);
        latched = recordIn;
        read_check(MSRP_OP_READ, 4'h1, 1, 0);
        $display("test 5 remote reset and relatch done");
        end_of_test();
    end
endmodule : meter_serial_readout_port_tb
`default_nettype wire
